// File: hdl/compact_timer_pwm_control.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
// Summary of operation
// - mode field: 00 compare output, 10 pwm, 11 timer, 01 undefined.
// - pwm pin function: inactive, active, waveform, 11 undefined; unused in timer.
// - output control: initial level in compare mode, active level in pwm mode.
// - requested level equal to present level leaves the pin unchanged.
// - enabling the unit in compare mode restores the initial pin level.
// - invert bit inverts the pin, no effect in timer mode.
// - swap bit exchanges period and duty sources in pwm mode.
// - clear source 1 clears the counter on compare a match.
// - clear source 0 clears on compare p; zero period means full overflow.
// - clear source bit is ignored in pwm mode.
// - pause freezes unit 1 counter and resumes from the held value.
// - unit 1 clock select picks system, prescaled, time base or external edge clock.
// - enable clears the counter; disable stops it keeping its value.
// - unit 0 period compares counter bits 9..7; zero means 1024.
// - readable counter and writable compare a for each unit.
// - compare mode raises a and p flags; clearing on a raises only a.
// - duty at or above period gives full active pwm output.
module compact_timer_pwm_control #(
  parameter int U0_W  = 10,
  parameter int U0_PW = 3,
  parameter int U1_W  = 16,
  parameter int U1_PW = 8
) (
  // clock and reset
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  // apb slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [compact_timer_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [compact_timer_pkg::DATA_W-1:0]  pwdata,
  output logic      [compact_timer_pkg::DATA_W-1:0]  prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // counting clock sources
  input  wire logic                                  high_speed_clock,
  input  wire logic                                  time_base_clock,
  input  wire logic                                  unit1_external_clock_pin,
  // timer outputs
  output logic                                       unit0_output_pin_a,
  output logic                                       unit0_output_pin_b,
  output logic                                       unit1_output_pin_a,
  output logic                                       unit1_output_pin_b
);
  import compact_timer_pkg::*;

  logic [7:0]       unit0_run_control_q;
  logic [7:0]       unit0_mode_output_control_q;
  logic [U0_W-1:0]  unit0_compare_a_value_q;
  logic [7:0]       unit1_run_clock_control_q;
  logic [7:0]       unit1_mode_output_control_q;
  logic [U1_W-1:0]  unit1_compare_a_value_q;
  logic [7:0]       unit1_period_compare_q;
  logic [3:0]       flags_q;
  logic [3:0]       flag_set;
  logic [U0_W-1:0]  unit0_count;
  logic [U1_W-1:0]  unit1_count;
  logic             unit0_pin;
  logic             unit1_pin;
  logic [1:0]       sys_div_q;
  logic [5:0]       hs_div_q;
  logic             ext_q;
  logic             unit1_tick;
  logic             wr;
  logic             rd_setup;
  logic             mapped;
  logic [DATA_W-1:0] rd_val;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  assign pready  = 1'b1;
  assign mapped  = hit(paddr, OFS_U0_RUN) | hit(paddr, OFS_U0_MODE) | hit(paddr, OFS_U0_COUNT)
                 | hit(paddr, OFS_U0_CMP_A) | hit(paddr, OFS_U1_RUN) | hit(paddr, OFS_U1_MODE)
                 | hit(paddr, OFS_U1_COUNT) | hit(paddr, OFS_U1_CMP_A) | hit(paddr, OFS_U1_PERIOD)
                 | hit(paddr, OFS_FLAGS);
  assign pslverr = psel & penable & ~mapped;
  assign wr      = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit0_run_control_q         <= RST_CTRL;
      unit0_mode_output_control_q <= RST_CTRL;
      unit1_run_clock_control_q   <= RST_CTRL;
      unit1_mode_output_control_q <= RST_CTRL;
      unit1_period_compare_q      <= RST_CTRL;
    end
    else if (wr)
    begin
      if (hit(paddr, OFS_U0_RUN))
        unit0_run_control_q <= pwdata[7:0];
      if (hit(paddr, OFS_U0_MODE))
        unit0_mode_output_control_q <= pwdata[7:0];
      if (hit(paddr, OFS_U1_RUN))
        unit1_run_clock_control_q <= pwdata[7:0] & U1_RUN_MASK;
      if (hit(paddr, OFS_U1_MODE))
        unit1_mode_output_control_q <= pwdata[7:0];
      if (hit(paddr, OFS_U1_PERIOD))
        unit1_period_compare_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit0_compare_a_value_q <= RST_CMP_A[U0_W-1:0];
      unit1_compare_a_value_q <= RST_CMP_A[U1_W-1:0];
    end
    else if (wr)
    begin
      if (hit(paddr, OFS_U0_CMP_A))
        unit0_compare_a_value_q <= pwdata[U0_W-1:0];
      if (hit(paddr, OFS_U1_CMP_A))
        unit1_compare_a_value_q <= pwdata[U1_W-1:0];
    end
  end

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_q <= RST_FLAGS;
    else if (wr && hit(paddr, OFS_FLAGS))
      flags_q <= (flags_q & ~pwdata[3:0]) | flag_set;
    else
      flags_q <= flags_q | flag_set;
  end

  always_comb
  begin
    rd_val = '0;
    if (hit(paddr, OFS_U0_RUN))
      rd_val[7:0] = unit0_run_control_q;
    if (hit(paddr, OFS_U0_MODE))
      rd_val[7:0] = unit0_mode_output_control_q;
    if (hit(paddr, OFS_U0_COUNT))
      rd_val[U0_W-1:0] = unit0_count;
    if (hit(paddr, OFS_U0_CMP_A))
      rd_val[U0_W-1:0] = unit0_compare_a_value_q;
    if (hit(paddr, OFS_U1_RUN))
      rd_val[7:0] = unit1_run_clock_control_q;
    if (hit(paddr, OFS_U1_MODE))
      rd_val[7:0] = unit1_mode_output_control_q;
    if (hit(paddr, OFS_U1_COUNT))
      rd_val[U1_W-1:0] = unit1_count;
    if (hit(paddr, OFS_U1_CMP_A))
      rd_val[U1_W-1:0] = unit1_compare_a_value_q;
    if (hit(paddr, OFS_U1_PERIOD))
      rd_val[7:0] = unit1_period_compare_q;
    if (hit(paddr, OFS_FLAGS))
      rd_val[3:0] = flags_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (rd_setup)
      prdata <= rd_val;
  end

  // prescalers for unit 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sys_div_q <= '0;
    else
      sys_div_q <= sys_div_q + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hs_div_q <= '0;
    else if (high_speed_clock)
      hs_div_q <= hs_div_q + 6'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_q <= 1'b0;
    else
      ext_q <= unit1_external_clock_pin;
  end

  always_comb
  begin
    case (clock_sel_t'(unit1_run_clock_control_q[RUN_CLK_SEL_HI:RUN_CLK_SEL_LO]))
      CLK_SYS_DIV4:  unit1_tick = (sys_div_q == SYS_DIV4_LAST);
      CLK_SYS:       unit1_tick = 1'b1;
      CLK_HS_DIV16:  unit1_tick = high_speed_clock & (hs_div_q[3:0] == HS_DIV16_LAST[3:0]);
      CLK_HS_DIV64:  unit1_tick = high_speed_clock & (hs_div_q == HS_DIV64_LAST);
      CLK_TIME_BASE: unit1_tick = time_base_clock;
      CLK_EXT_RISE:  unit1_tick = unit1_external_clock_pin & ~ext_q;
      CLK_EXT_FALL:  unit1_tick = ~unit1_external_clock_pin & ext_q;
      default:       unit1_tick = 1'b0;
    endcase
  end

  compact_timer_unit #(
    .W  (U0_W),
    .PW (U0_PW)
  ) u_unit0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (1'b1),
    .on       (unit0_run_control_q[RUN_ON_BIT]),
    .pause    (unit0_run_control_q[RUN_PAUSE_BIT]),
    .mode     (unit0_mode_output_control_q[MODE_HI:MODE_LO]),
    .pin_func (unit0_mode_output_control_q[FUNC_HI:FUNC_LO]),
    .oc       (unit0_mode_output_control_q[OC_BIT]),
    .pol      (unit0_mode_output_control_q[POL_BIT]),
    .dpx      (unit0_mode_output_control_q[DPX_BIT]),
    .cclr     (unit0_mode_output_control_q[CCLR_BIT]),
    .period   (unit0_run_control_q[RUN_PERIOD_LO +: U0_PW]),
    .cmp_a    (unit0_compare_a_value_q),
    .count_q  (unit0_count),
    .pin_q    (unit0_pin),
    .flag_a_q (flag_set[FLAG_U0_A]),
    .flag_p_q (flag_set[FLAG_U0_P])
  );

  compact_timer_unit #(
    .W  (U1_W),
    .PW (U1_PW)
  ) u_unit1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (unit1_tick),
    .on       (unit1_run_clock_control_q[RUN_ON_BIT]),
    .pause    (unit1_run_clock_control_q[RUN_PAUSE_BIT]),
    .mode     (unit1_mode_output_control_q[MODE_HI:MODE_LO]),
    .pin_func (unit1_mode_output_control_q[FUNC_HI:FUNC_LO]),
    .oc       (unit1_mode_output_control_q[OC_BIT]),
    .pol      (unit1_mode_output_control_q[POL_BIT]),
    .dpx      (unit1_mode_output_control_q[DPX_BIT]),
    .cclr     (unit1_mode_output_control_q[CCLR_BIT]),
    .period   (unit1_period_compare_q[U1_PW-1:0]),
    .cmp_a    (unit1_compare_a_value_q),
    .count_q  (unit1_count),
    .pin_q    (unit1_pin),
    .flag_a_q (flag_set[FLAG_U1_A]),
    .flag_p_q (flag_set[FLAG_U1_P])
  );

  // both pins of a unit carry the same signal
  assign unit0_output_pin_a = unit0_pin;
  assign unit0_output_pin_b = unit0_pin;
  assign unit1_output_pin_a = unit1_pin;
  assign unit1_output_pin_b = unit1_pin;

  a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_set != 4'h0) |=> ((flags_q & $past(flag_set)) == $past(flag_set))) else $error("flag event lost");

  a_reserved_clock: assert property (@(posedge pclk) disable iff (!presetn)
    (unit1_run_clock_control_q[RUN_CLK_SEL_HI:RUN_CLK_SEL_LO] == CLK_RESERVED) |-> !unit1_tick)
    else $error("counting on reserved clock");

  a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, OFS_U0_MODE)) |=> (unit0_mode_output_control_q == $past(pwdata[7:0])))
    else $error("mode write lost");

  a_cmp_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, OFS_U1_CMP_A)) |=> (unit1_compare_a_value_q == $past(pwdata[U1_W-1:0])))
    else $error("compare a write lost");

  a_count_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && hit(paddr, OFS_U1_COUNT)) |=> (prdata[U1_W-1:0] == $past(unit1_count)))
    else $error("counter read wrong");

  a_run_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, OFS_U1_RUN)) |=> (unit1_run_clock_control_q[2:0] == 3'h0))
    else $error("unit 1 run low bits set");

  a_ext_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (unit1_run_clock_control_q[RUN_CLK_SEL_HI:RUN_CLK_SEL_LO] == CLK_EXT_RISE && unit1_tick)
    |-> $rose(unit1_external_clock_pin)) else $error("tick without rising edge");

  a_ext_fall: assert property (@(posedge pclk) disable iff (!presetn)
    (unit1_run_clock_control_q[RUN_CLK_SEL_HI:RUN_CLK_SEL_LO] == CLK_EXT_FALL && unit1_tick)
    |-> $fell(unit1_external_clock_pin)) else $error("tick without falling edge");

  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, OFS_FLAGS) && pwdata[FLAG_U0_P] && !flag_set[FLAG_U0_P]) |=> !flags_q[FLAG_U0_P])
    else $error("flag not cleared");

  a_pause_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (unit1_run_clock_control_q[RUN_PAUSE_BIT] && $stable(unit1_run_clock_control_q)) |=> $stable(unit1_count))
    else $error("unit 1 moved while paused");

endmodule

// File: hdl/compact_timer_pkg.sv
package compact_timer_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef logic [1:0] mode_t;
  typedef logic [1:0] pin_func_t;
  typedef logic [2:0] clock_sel_t;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_U0_RUN     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_U0_MODE    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_U0_COUNT   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_U0_CMP_A   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_U1_RUN     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_U1_MODE    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_U1_COUNT   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_U1_CMP_A   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_U1_PERIOD  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_FLAGS      = 8'h24;

  // reset values
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [15:0] RST_CMP_A  = 16'h0000;
  localparam logic [3:0]  RST_FLAGS  = 4'h0;

  // run/clock control fields
  localparam int RUN_PAUSE_BIT  = 7;
  localparam int RUN_CLK_SEL_HI = 6;
  localparam int RUN_CLK_SEL_LO = 4;
  localparam int RUN_ON_BIT     = 3;
  localparam int RUN_PERIOD_LO  = 0;
  localparam logic [7:0] U1_RUN_MASK = 8'hF8;

  // mode/output control fields
  localparam int MODE_HI  = 7;
  localparam int MODE_LO  = 6;
  localparam int FUNC_HI  = 5;
  localparam int FUNC_LO  = 4;
  localparam int OC_BIT   = 3;
  localparam int POL_BIT  = 2;
  localparam int DPX_BIT  = 1;
  localparam int CCLR_BIT = 0;

  // flag register bits
  localparam int FLAG_U0_A = 0;
  localparam int FLAG_U0_P = 1;
  localparam int FLAG_U1_A = 2;
  localparam int FLAG_U1_P = 3;

  localparam mode_t MODE_COMPARE = 2'h0;
  localparam mode_t MODE_PWM     = 2'h2;
  localparam mode_t MODE_TIMER   = 2'h3;

  localparam pin_func_t FUNC_NONE   = 2'h0;
  localparam pin_func_t FUNC_LOW    = 2'h1;
  localparam pin_func_t FUNC_HIGH   = 2'h2;
  localparam pin_func_t FUNC_TOGGLE = 2'h3;
  localparam pin_func_t FUNC_PWM_INACTIVE = 2'h0;
  localparam pin_func_t FUNC_PWM_ACTIVE   = 2'h1;
  localparam pin_func_t FUNC_PWM_WAVE     = 2'h2;

  localparam clock_sel_t CLK_SYS_DIV4  = 3'h0;
  localparam clock_sel_t CLK_SYS       = 3'h1;
  localparam clock_sel_t CLK_HS_DIV16  = 3'h2;
  localparam clock_sel_t CLK_HS_DIV64  = 3'h3;
  localparam clock_sel_t CLK_TIME_BASE = 3'h4;
  localparam clock_sel_t CLK_RESERVED  = 3'h5;
  localparam clock_sel_t CLK_EXT_RISE  = 3'h6;
  localparam clock_sel_t CLK_EXT_FALL  = 3'h7;

  // prescaler terminal counts
  localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
  localparam logic [5:0] HS_DIV16_LAST = 6'h0F;
  localparam logic [5:0] HS_DIV64_LAST = 6'h3F;

endpackage

// File: hdl/compact_timer_unit.sv
`timescale 1ns/1ns
module compact_timer_unit #(
  parameter int W  = 10,
  parameter int PW = 3
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // counting and control
  input  wire logic                      tick,
  input  wire logic                      on,
  input  wire logic                      pause,
  input  wire compact_timer_pkg::mode_t  mode,
  input  wire compact_timer_pkg::pin_func_t pin_func,
  input  wire logic                      oc,
  input  wire logic                      pol,
  input  wire logic                      dpx,
  input  wire logic                      cclr,
  input  wire logic [PW-1:0]             period,
  input  wire logic [W-1:0]              cmp_a,
  // state
  output logic [W-1:0]                   count_q,
  output logic                           pin_q,
  output logic                           flag_a_q,
  output logic                           flag_p_q
);
  import compact_timer_pkg::*;

  localparam logic [W:0] FULL = {1'b1, {W{1'b0}}};

  logic       on_q;
  logic       level_q;
  logic       on_rise;
  logic       run;
  logic       is_pwm;
  logic       is_cmp;
  logic [W:0] nxt;
  logic [W:0] per_ext;
  logic [W:0] a_ext;
  logic [W:0] cyc_ext;
  logic [W:0] duty_ext;
  logic       a_reach;
  logic       p_reach;
  logic       a_event;
  logic       clr;
  logic       wave;
  logic       act;

  assign on_rise  = on & ~on_q;
  assign run      = tick & on & ~pause & ~on_rise;
  assign is_pwm   = (mode == MODE_PWM);
  assign is_cmp   = (mode == MODE_COMPARE);
  assign nxt      = {1'b0, count_q} + (W+1)'(1);
  // period on top counter bits, zero means full range
  assign per_ext  = (period == '0) ? FULL : {1'b0, period, {(W-PW){1'b0}}};
  assign a_ext    = (cmp_a == '0) ? FULL : {1'b0, cmp_a};
  // match when the counter reaches compare A
  assign a_reach  = (nxt == a_ext);
  assign p_reach  = (nxt == per_ext);
  assign a_event  = run & a_reach & (cmp_a != '0);
  assign cyc_ext  = dpx ? a_ext : per_ext;
  assign duty_ext = dpx ? per_ext : {1'b0, cmp_a};
  assign clr      = is_pwm ? (nxt == cyc_ext) : (cclr ? a_reach : p_reach);
  // duty at or above period gives full duty
  assign wave     = ({1'b0, count_q} < duty_ext) | (duty_ext >= cyc_ext);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      on_q <= 1'b0;
    else
      on_q <= on;
  end

  // reset on enable, hold while off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= '0;
    else if (on_rise)
      count_q <= '0;
    else if (run)
      count_q <= clr ? '0 : nxt[W-1:0];
  end

  // p flag only when clearing on comparator p, or in pwm
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end
    else
    begin
      flag_a_q <= a_event;
      flag_p_q <= run & p_reach & (is_pwm | ~cclr);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_q <= 1'b0;
    else if (on_rise && is_cmp)
      level_q <= oc;
    else if (a_event && is_cmp)
    begin
      case (pin_func)
        FUNC_LOW:    level_q <= 1'b0;
        FUNC_HIGH:   level_q <= 1'b1;
        FUNC_TOGGLE: level_q <= ~level_q;
        default:     level_q <= level_q;
      endcase
    end
  end

  always_comb
  begin
    case (pin_func)
      FUNC_PWM_ACTIVE: act = 1'b1;
      FUNC_PWM_WAVE:   act = wave;
      default:         act = 1'b0;
    endcase
  end

  // active level and inversion, unused in timer mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_q <= 1'b0;
    else if (is_cmp)
      pin_q <= level_q ^ pol;
    else if (is_pwm)
      pin_q <= (oc ? act : ~act) ^ pol;
    else
      pin_q <= 1'b0;
  end

  a_enable_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(on) |=> (count_q == '0)) else $error("counter not cleared on enable");

  a_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!on || pause) |=> $stable(count_q)) else $error("counter moved while off or paused");

  a_initial_level: assert property (@(posedge pclk) disable iff (!presetn)
    (on && !on_q && is_cmp) |=> (level_q == $past(oc))) else $error("initial level not restored");

  a_toggle_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (a_event && is_cmp && pin_func == FUNC_TOGGLE) |=> (level_q != $past(level_q)))
    else $error("toggle on match missing");

  a_clear_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && is_cmp && cclr && a_reach) |=> (count_q == '0)) else $error("no clear on compare a");

  a_clear_on_p: assert property (@(posedge pclk) disable iff (!presetn)
    (run && is_cmp && !cclr && p_reach) |=> (count_q == '0) ##0 flag_p_q)
    else $error("no clear or flag on compare p");

  a_no_p_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (!is_pwm && cclr) |=> !flag_p_q) else $error("p flag raised while clearing on a");

  a_full_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (is_pwm && pin_func == FUNC_PWM_WAVE && duty_ext >= cyc_ext) |=> (pin_q == ($past(oc) ^ $past(pol))))
    else $error("full duty not held active");

  a_timer_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_TIMER) |=> !pin_q) else $error("pin driven in timer mode");

endmodule

// File: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import compact_timer_pkg::*;
  typedef struct {
    logic [7:0]  mode;
    logic [7:0]  run;
    logic [15:0] cmpa;
    int          win;
    int          hi;
  } row_t;
  logic              pclk = 1'b0;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              hs_clk = 1'b0;
  logic              tb_clk = 1'b0;
  logic              ext_pin = 1'b0;
  logic [3:0]        div_q = 4'h0;
  logic              p0a;
  logic              p0b;
  logic              p1a;
  logic              p1b;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] c1;
  logic              err;
  int                bad_count = 0;
  int                total_checks = 0;
  int                hi;
  int                n_exp;
  int                lo;
  int                hb;
  int                div_tab [8] = '{4, 1, 32, 128, 16, 0, 16, 16};
  // unit 0: control, run, compare a, window, expected high cycles
  row_t              rows [16] = '{
    '{8'hA8, 8'h09, 16'h0020, 128, 32}, '{8'hAC, 8'h09, 16'h0020, 128, 96},
    '{8'hA0, 8'h09, 16'h0020, 128, 96}, '{8'hA8, 8'h09, 16'h00C8, 128, 128},
    '{8'hAA, 8'h09, 16'h0100, 256, 128}, '{8'h98, 8'h09, 16'h0020, 128, 128},
    '{8'h88, 8'h09, 16'h0020, 128, 0}, '{8'hA9, 8'h09, 16'h0020, 128, 32},
    '{8'hA8, 8'h08, 16'h0100, 1024, 256}, '{8'hFC, 8'h09, 16'h0020, 128, 0},
    '{8'h31, 8'h08, 16'h000A, 100, 50}, '{8'h29, 8'h08, 16'h000A, 100, 100},
    '{8'h21, 8'h08, 16'h000A, 100, 100}, '{8'h19, 8'h08, 16'h000A, 100, 0},
    '{8'h09, 8'h08, 16'h000A, 100, 100}, '{8'h25, 8'h08, 16'h000A, 100, 0}};

  compact_timer_pwm_control i_dut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .high_speed_clock         (hs_clk),
    .time_base_clock          (tb_clk),
    .unit1_external_clock_pin (ext_pin),
    .unit0_output_pin_a       (p0a),
    .unit0_output_pin_b       (p0b),
    .unit1_output_pin_a       (p1a),
    .unit1_output_pin_b       (p1b)
  );

  always #25 pclk = ~pclk;

  // counting sources: fast strobe every 2nd cycle, slow strobe every 16th, pin edge every 8th
  always @(posedge pclk)
  begin
    div_q  <= div_q + 4'h1;
    hs_clk <= ~hs_clk;
    tb_clk <= (div_q == 4'h7);
    if (div_q[2:0] == 3'h7)
      ext_pin <= ~ext_pin;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("[FAIL] %0t ns: got %h, want %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      bad_count++;
      end_sim();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [31:0] w, input logic [31:0] want);
    apb(1'b1, a, w);
    apb(1'b0, a, 32'h0);
    check(rd, want);
  endtask

  task automatic count_high(input int win);
    hi = 0;
    repeat (win)
    begin
      @(posedge pclk);
      if (p0a === 1'b1)
        hi++;
    end
    check({31'h0, p0b}, {31'h0, p0a}); // both pins agree
  endtask

  task automatic rst();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial
  begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    end_sim();
  end

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    rst();
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, OFS_U0_RUN, 32'h0); // off before mode change
      apb(1'b1, OFS_U0_CMP_A, {16'h0, rows[i].cmpa});
      apb(1'b1, OFS_U0_MODE, {24'h0, rows[i].mode});
      apb(1'b1, OFS_U0_RUN, {24'h0, rows[i].run});
      repeat (20) @(posedge pclk);
      count_high(rows[i].win);
      check(32'(hi), 32'(rows[i].hi));
    end
    // second reset in mid-run, then every register reads zero
    rst();
    for (int a = 0; a <= 36; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      check(rd, 32'h0); // reset value
      check({31'h0, err}, 32'h0); // mapped address
    end
    wr_rd(OFS_U1_RUN, 32'hFF, 32'hF8); // unit1 low run bits read zero
    wr_rd(OFS_U1_PERIOD, 32'h1FF, 32'hFF); // period compare width
    wr_rd(OFS_U0_CMP_A, 32'hFFFF, 32'h3FF); // compare a width
    wr_rd(OFS_U1_CMP_A, 32'h1ABCD, 32'hABCD); // compare a width
    wr_rd(OFS_U0_COUNT, 32'h3FF, 32'h0); // counter is read only
    wr_rd(8'h28, 32'h5, 32'h0); // unmapped reads zero
    check({31'h0, err}, 32'h1); // unmapped flagged
    apb(1'b1, OFS_U1_RUN, 32'h0);
    apb(1'b1, OFS_U1_PERIOD, 32'h0);
    apb(1'b1, OFS_U0_CMP_A, 32'h0A);
    apb(1'b1, OFS_U0_MODE, 32'h21);
    apb(1'b1, OFS_U0_RUN, 32'h08);
    repeat (30) @(posedge pclk);
    check({31'h0, p0a}, 32'h1); // pin set on match
    apb(1'b1, OFS_U0_RUN, 32'h0);
    apb(1'b1, OFS_U0_RUN, 32'h08);
    repeat (3) @(posedge pclk);
    check({31'h0, p0a}, 32'h0); // re-enable restores initial level
    apb(1'b1, OFS_U0_RUN, 32'h0);
    apb(1'b1, OFS_U0_MODE, 32'h00);
    apb(1'b1, OFS_U0_CMP_A, 32'd50);
    apb(1'b1, OFS_FLAGS, 32'hF);
    apb(1'b1, OFS_U0_RUN, 32'h09);
    repeat (300) @(posedge pclk);
    apb(1'b0, OFS_FLAGS, 32'h0);
    check({30'h0, rd[FLAG_U0_P], rd[FLAG_U0_A]}, 32'h3); // both flags with p clear
    apb(1'b0, OFS_U0_COUNT, 32'h0);
    check({31'h0, rd < 128}, 32'h1); // cleared at period 128
    apb(1'b1, OFS_U0_RUN, 32'h0);
    apb(1'b1, OFS_U0_MODE, 32'h01);
    apb(1'b1, OFS_U0_CMP_A, 32'd200);
    apb(1'b1, OFS_FLAGS, 32'hF);
    apb(1'b1, OFS_U0_RUN, 32'h09);
    repeat (500) @(posedge pclk);
    apb(1'b0, OFS_FLAGS, 32'h0);
    check({30'h0, rd[FLAG_U0_P], rd[FLAG_U0_A]}, 32'h1); // only a flag with a clear
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, OFS_U1_RUN, 32'(s) << 4);
      apb(1'b1, OFS_U1_RUN, (32'(s) << 4) | 32'h08);
      repeat (1024) @(posedge pclk);
      apb(1'b1, OFS_U1_RUN, (32'(s) << 4) | 32'h88);
      apb(1'b0, OFS_U1_COUNT, 32'h0);
      n_exp = (div_tab[s] > 0) ? 1024 / div_tab[s] : 0;
      lo    = (n_exp > 0) ? n_exp - 1 : 0;
      hb    = (n_exp > 0) ? n_exp + 6 : 0;
      check({31'h0, (rd >= lo) && (rd <= hb)}, 32'h1); // counting rate per source
    end
    apb(1'b1, OFS_U1_RUN, 32'h18);
    repeat (10) @(posedge pclk);
    apb(1'b1, OFS_U1_RUN, 32'h98);
    apb(1'b0, OFS_U1_COUNT, 32'h0);
    c1 = rd;
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_U1_COUNT, 32'h0);
    check(rd, c1); // paused count holds
    apb(1'b1, OFS_U1_RUN, 32'h18);
    apb(1'b1, OFS_U1_RUN, 32'h98);
    apb(1'b0, OFS_U1_COUNT, 32'h0);
    check({31'h0, (rd > c1) && (rd <= c1 + 8)}, 32'h1); // resumes from held value
    apb(1'b1, OFS_U1_RUN, 32'h18);
    apb(1'b1, OFS_U1_RUN, 32'h10);
    apb(1'b0, OFS_U1_COUNT, 32'h0);
    c1 = rd;
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_U1_COUNT, 32'h0);
    check(rd, c1); // off keeps residual value
    apb(1'b1, OFS_U1_RUN, 32'h18);
    apb(1'b0, OFS_U1_COUNT, 32'h0);
    check({31'h0, rd < 8}, 32'h1); // enable restarts from zero
    apb(1'b1, OFS_U1_PERIOD, 32'h1);
    apb(1'b1, OFS_FLAGS, 32'hF);
    apb(1'b1, OFS_U1_RUN, 32'h10);
    apb(1'b1, OFS_U1_RUN, 32'h18);
    repeat (600) @(posedge pclk);
    apb(1'b0, OFS_FLAGS, 32'h0);
    check({31'h0, rd[FLAG_U1_P]}, 32'h1); // period match at 256
    apb(1'b0, OFS_U1_COUNT, 32'h0);
    check({31'h0, rd < 256}, 32'h1); // cleared at period 256
    apb(1'b1, OFS_U1_RUN, 32'h10); // off before mode change
    apb(1'b1, OFS_U1_MODE, 32'h98);
    @(posedge pclk);
    check({30'h0, p1b, p1a}, 32'h3); // unit 1 forced active
    end_sim();
  end
endmodule
